// ### design/exec_pkg.sv
// Constants, codes and state layout for the bit-branch execution unit
// Notes on behaviour
// RL1: Clear form, memory bit set: branch to PC+4+offset, clear the bit.
// RL2: Clear form, special-function bit set: branch to PC+4+offset, clear it.
// RL3: Clear form, accumulator bit set: branch to PC+3+offset, clear it.
// RL4: Clear form, X register bit set: branch to PC+3+offset, clear it.
// RL5: Clear form, status byte bit set: branch to PC+3+offset, clear it.
// RL6: Set form, memory bit clear: branch to PC+4+offset, set the bit.
// RL7: Set form, special-function bit clear: branch to PC+4+offset, set it.
// RL8: Set form, accumulator or X bit clear: branch to PC+3+offset, set it.
// RL9: Set form, status byte bit clear: branch to PC+3+offset, set it.
// RL10: Counter loop decrements, then branches to PC+2+offset if nonzero.
// RL11: Memory byte loop decrements, then branches to PC+3+offset if nonzero.
// RL12: Call swaps PC, R5/R4; status to R7/R6; bank n; select, enable 0.
// RL13: Returns: PC from R5/R4, operand to R5/R4, status from R7/R6.
// RL14: The 8-bit offset is signed two's complement.
// RL15: Unmet condition: next instruction, tested bit unchanged.
package exec_pkg;
    // Register byte offsets
    localparam logic [7:0] CMD_OFS = 8'h00;
    localparam logic [7:0] PC_OFS = 8'h04;
    localparam logic [7:0] PSW_OFS = 8'h08;
    localparam logic [7:0] ACCX_OFS = 8'h0c;
    localparam logic [7:0] COUNT_OFS = 8'h10;
    localparam logic [7:0] MEM_OFS = 8'h14;
    localparam logic [7:0] BANKREG_OFS = 8'h18;
    localparam logic [7:0] OPADDR_OFS = 8'h1c;
    localparam logic [7:0] STATUS_OFS = 8'h20;
    // Command field positions
    localparam int CMD_OP_POS = 0;
    localparam int CMD_BIT_POS = 8;
    localparam int CMD_DISP_POS = 16;
    // Status word high fields
    localparam int BANK_POS = 4;
    localparam int SETSEL_POS = 3;
    localparam int INTEN_POS = 0;
    // Instruction lengths
    localparam logic [2:0] LEN2 = 3'h2;
    localparam logic [2:0] LEN3 = 3'h3;
    localparam logic [2:0] LEN4 = 3'h4;
    // Reset values
    localparam logic [15:0] PC_RST = 16'h0000;
    localparam logic [7:0] BYTE_RST = 8'h00;
    // Bus responses
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    // Operation codes: bits 2:0 pick the tested byte, bit 3 the set form
    typedef enum logic [4:0] {
        CLR_SADDR = 5'b00000,
        CLR_SFR = 5'b00001,
        CLR_ACC = 5'b00010,
        CLR_X = 5'b00011,
        CLR_STH = 5'b00100,
        CLR_STL = 5'b00101,
        SET_SADDR = 5'b01000,
        SET_SFR = 5'b01001,
        SET_ACC = 5'b01010,
        SET_X = 5'b01011,
        SET_STH = 5'b01100,
        SET_STL = 5'b01101,
        LOOP_COUNT = 5'b10000,
        LOOP_SADDR = 5'b10001,
        CS_CALL = 5'b10010,
        CS_RET = 5'b10011,
        CS_RET_LONG = 5'b10100
    } op_type;
    // Tested byte selectors
    localparam logic [2:0] SEL_SADDR = 3'h0;
    localparam logic [2:0] SEL_SFR = 3'h1;
    localparam logic [2:0] SEL_ACC = 3'h2;
    localparam logic [2:0] SEL_X = 3'h3;
    localparam logic [2:0] SEL_STH = 3'h4;
    localparam logic [2:0] SEL_STL = 3'h5;
endpackage : exec_pkg

// ### design/branch_target.sv
// Relative branch target adder
`timescale 1ns/1ps
`default_nettype none
module branch_target
(
    // Instruction address and length
    input wire logic [15:0] pc,
    input wire logic [2:0] length,
    // Signed offset
    input wire logic [7:0] offset,
    // Result
    output logic [15:0] target
);
    // Offset sign-extended before the add, see RL14
    assign target = pc + {13'h0, length} + {{8{offset[7]}}, offset};
endmodule : branch_target
`default_nettype wire

// ### design/exec_core.sv
// Bit-branch, loop and context-switch executor with AXI4-Lite registers
//
// Implementation choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
module exec_core
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Write address
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    // Write data
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // Write response
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // Read address
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    // Read data
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready
);
    import exec_pkg::*;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic aw_have;
        logic w_have;
        logic [7:0] waddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic [15:0] pc;
        logic [7:0] psw_h;
        logic [7:0] psw_l;
        logic [7:0] acc;
        logic [7:0] xreg;
        logic [7:0] count;
        logic [7:0] sbyte;
        logic [7:0] sfr;
        logic [15:0] opaddr;
        logic [31:0] cmd;
        logic [7:0][31:0] bank;
        logic taken;
    } state_type;

    state_type st_r;
    state_type st_nxt;

    logic do_write;
    logic exec;
    op_type op;
    logic [2:0] bitn;
    logic [7:0] disp;
    logic [2:0] len;
    logic [15:0] target;
    logic [15:0] seq_pc;
    logic [2:0] cur_bank;
    logic [31:0] cur_regs;
    logic [31:0] new_regs;
    logic [7:0] tested_byte;

    function automatic logic [31:0] merge(input logic [31:0] o,
        input logic [31:0] n, input logic [3:0] s);
        logic [31:0] m;
        m = o;
        for (int i = 0; i < 4; i++)
        begin
            if (s[i])
            begin
                m[i*8 +: 8] = n[i*8 +: 8];
            end
        end
        return m;
    endfunction : merge

    function automatic logic mapped(input logic [7:0] a);
        return a == CMD_OFS || a == PC_OFS || a == PSW_OFS
            || a == ACCX_OFS || a == COUNT_OFS || a == MEM_OFS
            || a == BANKREG_OFS || a == OPADDR_OFS || a == STATUS_OFS;
    endfunction : mapped

    // Command decode
    assign do_write = st_r.aw_have && st_r.w_have && !st_r.bvalid;
    assign exec = do_write && st_r.waddr == CMD_OFS;
    assign op = op_type'(st_r.wdata[CMD_OP_POS +: 5]);
    assign bitn = st_r.wdata[CMD_BIT_POS +: 3];
    assign disp = st_r.wdata[CMD_DISP_POS +: 8];
    assign cur_bank = st_r.psw_h[BANK_POS +: 3];
    assign cur_regs = st_r.bank[cur_bank];
    assign new_regs = st_r.bank[bitn];

    // Length of each form
    always_comb
    begin
        if (op == LOOP_COUNT || op == CS_CALL)
        begin
            len = LEN2;
        end
        else if (op[4] == 1'b0 && op[2:1] == 2'b00)
        begin
            len = LEN4;
        end
        else if (op == CS_RET_LONG)
        begin
            len = LEN4;
        end
        else
        begin
            len = LEN3;
        end
    end

    always_comb
    begin
        case (op[2:0])
            SEL_SADDR: tested_byte = st_r.sbyte;
            SEL_SFR: tested_byte = st_r.sfr;
            SEL_ACC: tested_byte = st_r.acc;
            SEL_X: tested_byte = st_r.xreg;
            SEL_STH: tested_byte = st_r.psw_h;
            default: tested_byte = st_r.psw_l;
        endcase
    end

    assign seq_pc = st_r.pc + {13'h0, len};

    branch_target target_add
    (
        .pc(st_r.pc),
        .length(len),
        .offset(disp),
        .target(target)
    );

    always_comb
    begin
        logic cond;
        logic [7:0] nb;
        logic [7:0] dec;
        logic [31:0] wr;
        cond = 1'b0;
        nb = 8'h00;
        dec = 8'h00;
        wr = 32'h0000_0000;
        st_nxt = st_r;
        // Write address and data taken in either order
        st_nxt.awready = awvalid && !st_r.aw_have && !st_r.awready;
        st_nxt.wready = wvalid && !st_r.w_have && !st_r.wready;
        if (awvalid && st_r.awready)
        begin
            st_nxt.aw_have = 1'b1;
            st_nxt.waddr = awaddr;
        end
        if (wvalid && st_r.wready)
        begin
            st_nxt.w_have = 1'b1;
            st_nxt.wdata = wdata;
            st_nxt.wstrb = wstrb;
        end
        if (st_r.bvalid && bready)
        begin
            st_nxt.bvalid = 1'b0;
        end
        if (do_write)
        begin
            st_nxt.aw_have = 1'b0;
            st_nxt.w_have = 1'b0;
            st_nxt.bvalid = 1'b1;
            st_nxt.bresp = mapped(st_r.waddr) ? RESP_OKAY : RESP_SLVERR;
            wr = st_r.wdata;
            case (st_r.waddr)
                PC_OFS: st_nxt.pc = 16'(merge({16'h0, st_r.pc}, wr,
                    st_r.wstrb));
                PSW_OFS:
                begin
                    {st_nxt.psw_h, st_nxt.psw_l} = 16'(merge({16'h0,
                        st_r.psw_h, st_r.psw_l}, wr, st_r.wstrb));
                end
                ACCX_OFS:
                begin
                    {st_nxt.xreg, st_nxt.acc} = 16'(merge({16'h0,
                        st_r.xreg, st_r.acc}, wr, st_r.wstrb));
                end
                COUNT_OFS: st_nxt.count = 8'(merge({24'h0, st_r.count},
                    wr, st_r.wstrb));
                MEM_OFS:
                begin
                    {st_nxt.sfr, st_nxt.sbyte} = 16'(merge({16'h0,
                        st_r.sfr, st_r.sbyte}, wr, st_r.wstrb));
                end
                BANKREG_OFS: st_nxt.bank[cur_bank] = merge(cur_regs, wr,
                    st_r.wstrb);
                OPADDR_OFS: st_nxt.opaddr = 16'(merge({16'h0,
                    st_r.opaddr}, wr, st_r.wstrb));
                default: st_nxt.pc = st_r.pc;
            endcase
        end
        if (exec)
        begin
            st_nxt.pc = seq_pc; // see RL15
            st_nxt.cmd = st_r.wdata;
            case (op)
                CLR_SADDR, CLR_SFR, CLR_ACC, CLR_X, CLR_STH, CLR_STL,
                SET_SADDR, SET_SFR, SET_ACC, SET_X, SET_STH, SET_STL:
                begin
                    // Clear form wants 1, set form wants 0
                    cond = tested_byte[bitn] ^ op[3];
                    nb = tested_byte;
                    nb[bitn] = op[3];
                    st_nxt.taken = cond;
                    if (cond)
                    begin
                        st_nxt.pc = target; // see RL1 RL2 RL3 RL4 RL6 RL7
                        unique case (op[2:0])
                            SEL_SADDR: st_nxt.sbyte = nb; // see RL1 RL6
                            SEL_SFR: st_nxt.sfr = nb; // see RL2 RL7
                            SEL_ACC: st_nxt.acc = nb; // see RL3 RL8
                            SEL_X: st_nxt.xreg = nb; // see RL4 RL8
                            SEL_STH: st_nxt.psw_h = nb; // see RL5 RL9
                            SEL_STL: st_nxt.psw_l = nb; // see RL5 RL9
                        endcase
                    end
                end
                LOOP_COUNT, LOOP_SADDR:
                begin
                    dec = (op == LOOP_COUNT ? st_r.count : st_r.sbyte)
                        - 8'h01;
                    if (op == LOOP_COUNT)
                    begin
                        st_nxt.count = dec; // see RL10
                    end
                    else
                    begin
                        st_nxt.sbyte = dec; // see RL11
                    end
                    st_nxt.taken = dec != 8'h00;
                    if (dec != 8'h00)
                    begin
                        st_nxt.pc = target; // see RL10 RL11
                    end
                end
                CS_CALL:
                begin
                    // Swap PC with R5/R4 and save status, see RL12
                    st_nxt.pc = new_regs[15:0];
                    st_nxt.bank[bitn] = {st_r.psw_h, st_r.psw_l, seq_pc};
                    st_nxt.psw_h[BANK_POS +: 3] = bitn;
                    st_nxt.psw_h[SETSEL_POS] = 1'b0;
                    st_nxt.psw_h[INTEN_POS] = 1'b0;
                    st_nxt.taken = 1'b1;
                end
                CS_RET, CS_RET_LONG:
                begin
                    // Reload PC and status, park operand address, see RL13
                    st_nxt.pc = cur_regs[15:0];
                    st_nxt.bank[cur_bank] = {cur_regs[31:16], st_r.opaddr};
                    st_nxt.psw_h = cur_regs[31:24];
                    st_nxt.psw_l = cur_regs[23:16];
                    st_nxt.taken = 1'b1;
                end
                default: st_nxt.taken = 1'b0;
            endcase
        end
        // Read channel
        st_nxt.arready = arvalid && !st_r.arready && !st_r.rvalid;
        if (st_r.rvalid && rready)
        begin
            st_nxt.rvalid = 1'b0;
        end
        if (arvalid && st_r.arready)
        begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rresp = mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
            case (araddr)
                CMD_OFS: st_nxt.rdata = st_r.cmd;
                PC_OFS: st_nxt.rdata = {16'h0000, st_r.pc};
                PSW_OFS: st_nxt.rdata = {16'h0000, st_r.psw_h, st_r.psw_l};
                ACCX_OFS: st_nxt.rdata = {16'h0000, st_r.xreg, st_r.acc};
                COUNT_OFS: st_nxt.rdata = {24'h00_0000, st_r.count};
                MEM_OFS: st_nxt.rdata = {16'h0000, st_r.sfr, st_r.sbyte};
                BANKREG_OFS: st_nxt.rdata = cur_regs;
                OPADDR_OFS: st_nxt.rdata = {16'h0000, st_r.opaddr};
                STATUS_OFS: st_nxt.rdata = {31'h0000_0000, st_r.taken};
                default: st_nxt.rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            st_r <= '0;
            st_r.pc <= PC_RST;
            st_r.acc <= BYTE_RST;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign awready = st_r.awready;
    assign wready = st_r.wready;
    assign bvalid = st_r.bvalid;
    assign bresp = st_r.bresp;
    assign arready = st_r.arready;
    assign rvalid = st_r.rvalid;
    assign rresp = st_r.rresp;
    assign rdata = st_r.rdata;

    // Checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    clr_mem_a: assert property (exec && op == CLR_SADDR // see RL1
        && st_r.sbyte[bitn] |=> st_r.pc == $past(target)
        && !st_r.sbyte[$past(bitn)])
        else $error("memory bit clear branch wrong");
    clr_sfr_a: assert property (exec && op == CLR_SFR // see RL2
        && st_r.sfr[bitn] |=> st_r.pc == $past(st_r.pc) + 16'h0004
        + {{8{$past(disp[7])}}, $past(disp)} && !st_r.sfr[$past(bitn)])
        else $error("sfr bit clear branch wrong");
    clr_acc_a: assert property (exec && op == CLR_ACC // see RL3
        && st_r.acc[bitn] |=> st_r.pc == $past(st_r.pc) + 16'h0003
        + {{8{$past(disp[7])}}, $past(disp)} && !st_r.acc[$past(bitn)])
        else $error("accumulator bit clear branch wrong");
    clr_x_a: assert property (exec && op == CLR_X // see RL4
        && st_r.xreg[bitn] |=> !st_r.xreg[$past(bitn)] && st_r.taken)
        else $error("x bit clear wrong");
    clr_psw_a: assert property (exec && op == CLR_STL // see RL5
        && st_r.psw_l[bitn] |=> !st_r.psw_l[$past(bitn)])
        else $error("status bit clear wrong");
    set_mem_a: assert property (exec && op == SET_SADDR // see RL6
        && !st_r.sbyte[bitn] |=> st_r.sbyte[$past(bitn)]
        && st_r.pc == $past(target))
        else $error("memory bit set branch wrong");
    set_sfr_a: assert property (exec && op == SET_SFR // see RL7
        && !st_r.sfr[bitn] |=> st_r.sfr[$past(bitn)])
        else $error("sfr bit set wrong");
    set_reg_a: assert property (exec && op == SET_X // see RL8
        && !st_r.xreg[bitn] |=> st_r.xreg[$past(bitn)]
        && st_r.pc == $past(st_r.pc) + 16'h0003
        + {{8{$past(disp[7])}}, $past(disp)})
        else $error("x bit set branch wrong");
    set_psw_a: assert property (exec && op == SET_STH // see RL9
        && !st_r.psw_h[bitn] |=> st_r.psw_h[$past(bitn)])
        else $error("status bit set wrong");
    loop_count_a: assert property (exec && op == LOOP_COUNT // see RL10
        |=> st_r.count == $past(st_r.count) - 8'h01 && st_r.pc ==
        (st_r.count != 8'h00 ? $past(target) : $past(st_r.pc) + 16'h0002))
        else $error("register loop wrong");
    loop_mem_a: assert property (exec && op == LOOP_SADDR // see RL11
        |=> st_r.sbyte == $past(st_r.sbyte) - 8'h01
        && st_r.taken == (st_r.sbyte != 8'h00))
        else $error("memory loop wrong");
    cs_call_a: assert property (exec && op == CS_CALL // see RL12
        |=> st_r.psw_h[BANK_POS +: 3] == $past(bitn)
        && !st_r.psw_h[INTEN_POS]
        && !st_r.psw_h[SETSEL_POS] && st_r.pc == $past(new_regs[15:0])
        && cur_regs[31:16] == $past({st_r.psw_h, st_r.psw_l}))
        else $error("context call wrong");
    cs_ret_a: assert property (exec && op == CS_RET // see RL13
        |=> st_r.pc == $past(cur_regs[15:0])
        && {st_r.psw_h, st_r.psw_l} == $past(cur_regs[31:16]))
        else $error("context return wrong");
    not_taken_a: assert property (exec && op == CLR_ACC // see RL15
        && !st_r.acc[bitn] |=> st_r.pc == $past(seq_pc)
        && st_r.acc == $past(st_r.acc))
        else $error("untaken branch wrong");
    bresp_a: assert property (do_write |=> bvalid)
        else $error("write not answered");

    taken_c: cover property (exec ##1 st_r.taken);
    call_ret_c: cover property (exec && op == CS_CALL ##[1:40]
        exec && op == CS_RET);
    loop_end_c: cover property (exec && op == LOOP_COUNT ##1 !st_r.taken);
endmodule : exec_core
`default_nettype wire

// ### tb/bit_branch_context_switch_exec_tb_top.sv
// Self-checking bench for the bit-branch execution unit
`timescale 1ns/1ps
`default_nettype none
module bit_branch_context_switch_exec_tb_top;
import exec_pkg::*;
logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
logic arvalid, arready, rvalid, rready, taken_m;
logic [7:0] awaddr, araddr, cnt_m;
logic [31:0] wdata, rdata, rd_v;
logic [3:0] wstrb;
logic [1:0] bresp, rresp, rr_v;
logic [15:0] pc_m, psw_m, accx_m, mem_m, opaddr_m;
logic [31:0] bank_m [8];
int n_errors, check_count, seed, r, k;
int op_list [18] = '{'h00, 'h01, 'h02, 'h03, 'h04, 'h05, 'h08, 'h09,
    'h0a, 'h0b, 'h0c, 'h0d, 'h10, 'h11, 'h12, 'h13, 'h14, 'h07};

exec_core i_exec_core (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready));

initial
begin
    aclk = 1'h0;
    forever #50 aclk = ~aclk;
end

task complete_run;
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0)
        $display("Regression OK");
    else
        $display("Regression broken");
    $finish;
endtask : complete_run

task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
        n_errors++;
        $display("mismatch %s expected %h seen %h", what, exp, got);
    end
endtask : chk

task hung(input string what);
    n_errors++;
    $display("mismatch %s expected answer seen none", what);
    complete_run();
endtask : hung

task axi_write(input logic [7:0] a, input logic [31:0] d,
    input logic [1:0] er);
    int i;
    logic done;
    done = 1'h0;
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'h1;
    wdata <= d;
    wstrb <= 4'hf;
    wvalid <= 1'h1;
    bready <= 1'h1;
    for (i = 0; i < 40 && !done; i++)
    begin
        @(posedge aclk);
        if (awvalid && awready)
            awvalid <= 1'h0;
        if (wvalid && wready)
            wvalid <= 1'h0;
        if (bvalid)
        begin
            done = 1'h1;
            bready <= 1'h0;
            chk("bresp", {30'h0000_0000, er}, {30'h0000_0000, bresp});
        end
    end
    if (!done)
        hung("write");
endtask : axi_write

task axi_read(input logic [7:0] a);
    int i;
    logic done;
    done = 1'h0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    for (i = 0; i < 40 && !done; i++)
    begin
        @(posedge aclk);
        if (arvalid && arready)
            arvalid <= 1'h0;
        if (rvalid)
        begin
            done = 1'h1;
            rready <= 1'h0;
            rd_v = rdata;
            rr_v = rresp;
        end
    end
    if (!done)
        hung("read");
endtask : axi_read

task rd_chk(input string what, input logic [7:0] a, input logic [31:0] e);
    axi_read(a);
    chk(what, e, rd_v);
    chk("rresp", {30'h0000_0000, RESP_OKAY}, {30'h0000_0000, rr_v});
endtask : rd_chk

task check_all;
    rd_chk("pc", PC_OFS, {16'h0000, pc_m});
    rd_chk("psw", PSW_OFS, {16'h0000, psw_m});
    rd_chk("accx", ACCX_OFS, {16'h0000, accx_m});
    rd_chk("count", COUNT_OFS, {24'h00_0000, cnt_m});
    rd_chk("mem", MEM_OFS, {16'h0000, mem_m});
    rd_chk("bank", BANKREG_OFS, bank_m[psw_m[14:12]]);
    rd_chk("opaddr", OPADDR_OFS, {16'h0000, opaddr_m});
    rd_chk("taken", STATUS_OFS, {31'h0000_0000, taken_m});
endtask : check_all

task zero_model;
    pc_m = PC_RST;
    psw_m = 16'h0000;
    accx_m = 16'h0000;
    mem_m = 16'h0000;
    opaddr_m = 16'h0000;
    cnt_m = BYTE_RST;
    taken_m = 1'h0;
    foreach (bank_m[i])
        bank_m[i] = 32'h0000_0000;
endtask : zero_model

task load_state(input int corner);
    int b;
    {pc_m, psw_m} = $random(seed);
    {accx_m, mem_m} = $random(seed);
    {opaddr_m, cnt_m} = 24'($random(seed));
    if (corner == 0)
    begin
        cnt_m = 8'h01;
        mem_m[7:0] = 8'h01;
    end
    if (corner == 1)
    begin
        cnt_m = 8'h00;
        mem_m[7:0] = 8'h00;
    end
    for (b = 0; b < 8; b++)
    begin
        bank_m[b] = $random(seed);
        axi_write(PSW_OFS, {16'h0000, psw_m[15], 3'(b), psw_m[11:0]},
            RESP_OKAY);
        axi_write(BANKREG_OFS, bank_m[b], RESP_OKAY);
    end
    axi_write(PSW_OFS, {16'h0000, psw_m}, RESP_OKAY);
    axi_write(PC_OFS, {16'h0000, pc_m}, RESP_OKAY);
    axi_write(ACCX_OFS, {16'h0000, accx_m}, RESP_OKAY);
    axi_write(COUNT_OFS, {24'h00_0000, cnt_m}, RESP_OKAY);
    axi_write(MEM_OFS, {16'h0000, mem_m}, RESP_OKAY);
    axi_write(OPADDR_OFS, {16'h0000, opaddr_m}, RESP_OKAY);
endtask : load_state

task run_op(input logic [4:0] op, input logic [2:0] bt, input logic [7:0] off);
    logic [47:0] ops;
    logic [2:0] len;
    logic [2:0] cb;
    logic [31:0] ob;
    ops = {psw_m[7:0], psw_m[15:8], accx_m, mem_m};
    len = LEN3;
    taken_m = 1'h0;
    cb = psw_m[14:12];
    if (!op[4] && op[2:0] < SEL_STL + 3'h1)
    begin
        len = (op[2:1] == 2'h0) ? LEN4 : LEN3;
        taken_m = ops[op[2:0] * 8 + bt] ^ op[3];
        if (taken_m)
            ops[op[2:0] * 8 + bt] = op[3];
        mem_m = ops[15:0];
        accx_m = ops[31:16];
        psw_m = {ops[39:32], ops[47:40]};
    end
    else if (op == LOOP_COUNT)
    begin
        len = LEN2;
        cnt_m = cnt_m - 8'h01;
        taken_m = (cnt_m != 8'h00);
    end
    else if (op == LOOP_SADDR)
    begin
        mem_m[7:0] = mem_m[7:0] - 8'h01;
        taken_m = (mem_m[7:0] != 8'h00);
    end
    else
        taken_m = op == CS_CALL || op == CS_RET || op == CS_RET_LONG;
    if (op == CS_CALL)
    begin
        ob = bank_m[bt];
        bank_m[bt] = {psw_m, pc_m + 16'h0002};
        pc_m = ob[15:0];
        psw_m = {psw_m[15], bt, 1'h0, psw_m[10:9], 1'h0, psw_m[7:0]};
    end
    else if (op == CS_RET || op == CS_RET_LONG)
    begin
        pc_m = bank_m[cb][15:0];
        psw_m = bank_m[cb][31:16];
        bank_m[cb][15:0] = opaddr_m;
    end
    else
        pc_m = pc_m + len + (taken_m ? {{8{off[7]}}, off} : 16'h0000);
    axi_write(CMD_OFS, {8'h00, off, 5'h00, bt, 3'h0, op}, RESP_OKAY);
    rd_chk("cmd", CMD_OFS, {8'h00, off, 5'h00, bt, 3'h0, op});
    check_all();
    if (op == CS_RET || op == CS_RET_LONG)
    begin
        axi_write(PSW_OFS, {16'h0000, psw_m[15], cb, psw_m[11:0]}, RESP_OKAY);
        rd_chk("bank", BANKREG_OFS, bank_m[cb]);
        axi_write(PSW_OFS, {16'h0000, psw_m}, RESP_OKAY);
    end
endtask : run_op

initial
begin
    seed = 32'hb0e4_b16c;
    n_errors = 0;
    check_count = 0;
    aresetn = 1'h0;
    {awaddr, araddr, wdata, wstrb} = 52'h0_0000_0000_0000;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    zero_model();
    repeat (4) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    check_all();
    axi_write(8'h24, $random(seed), RESP_SLVERR);
    axi_read(8'h40);
    chk("rresp", {30'h0000_0000, RESP_SLVERR}, {30'h0000_0000, rr_v});
    chk("rdata", 32'h0000_0000, rd_v);
    check_all();
    for (r = 0; r < 8; r++)
        for (k = 0; k < 18; k++)
        begin
            load_state(r);
            run_op(5'(op_list[k]), 3'($random(seed)),
                (r == 0) ? 8'h80 : 8'($random(seed)));
        end
    load_state(2);
    run_op(CS_CALL, 3'h5, 8'h00);
    run_op(CLR_STH, 3'h6, 8'h7f);
    run_op(CS_RET_LONG, 3'h0, 8'h00);
    run_op(CS_CALL, 3'h2, 8'h00);
    run_op(CS_RET, 3'h0, 8'h00);
    aresetn <= 1'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    zero_model();
    @(posedge aclk);
    check_all();
    complete_run();
end
endmodule : bit_branch_context_switch_exec_tb_top
`default_nettype wire
